// *** core/ccs_clock_ctrl.sv ***
// Clock generator, domain selector and monitor control
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_clock_ctrl
    import ccs_pkg::*;
#(
    parameter int NI = `CCS_NUM_ISO,
    parameter int NA = `CCS_NUM_AWO,
    parameter int SW = `CCS_SRC_W,
    parameter int CW = 16,
    parameter int MON_WIN_CYC = `CCS_MON_WIN_CYC,
    parameter logic [NI-1:0] ISO_HAS_MASK = '1,
    parameter logic [NA-1:0] AWO_HAS_MASK = '1
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic power_up_reset_i,
    input wire logic system_reset_i,
    input wire logic standby_stop_request_i,
    input wire logic deep_stop_wakeup_reset_i,
    input wire logic wakeup_crystal_start_i,
    input wire logic [2:0] gen_enable_trg_i,
    input wire logic [2:0] gen_disable_trg_i,
    input wire logic gen_mask_wr_i,
    input wire logic [2:0] gen_stop_mask_i,
    input wire logic sel_wr_i,
    input wire logic sel_area_i,
    input wire logic [4:0] sel_index_i,
    input wire logic [SW-1:0] sel_source_i,
    input wire logic sel_stop_mask_i,
    input wire logic [2:0] mon_enable_i,
    input wire logic [2:0] mon_sup_clk_i,
    input wire logic [3*CW-1:0] mon_lo_limit_i,
    input wire logic [3*CW-1:0] mon_hi_limit_i,
    output logic [2:0] gen_running_o,
    output logic [NI*SW-1:0] iso_domain_source_o,
    output logic [NI-1:0] iso_domain_clock_out_o,
    output logic [NA*SW-1:0] awo_domain_source_o,
    output logic [NA-1:0] awo_domain_clock_out_o,
    output logic [2:0] monitor_reset_out_o,
    output logic [2:0] monitor_event_out_o
);
    // ********************************************************
    // Parameter checks
    // ********************************************************
    if (NI < 1 || NI > 32 || NA < 1 || NA > 32 || SW < 1) begin : g_chk
        $error("ccs_clock_ctrl: domain counts must be 1 to 32");
    end

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic stop_q;
        logic [2:0] gen_run;
        logic [2:0] gen_held;
        logic [2:0] gen_mask;
        logic [NI*SW-1:0] iso_src;
        logic [NI-1:0] iso_mask;
        logic [NI-1:0] iso_run;
        logic [NA*SW-1:0] awo_src;
        logic [NA-1:0] awo_mask;
        logic [NA-1:0] awo_run;
    } ccs_ctl_t;

    ccs_ctl_t s_r;
    ccs_ctl_t s_nxt;
    logic stop_rise;
    logic stop_fall;
    logic [2:0] gen_reset;
    logic [2:0] mon_active;

    // One selector per domain, picked by area and index
    function automatic logic ccs_sel_hit(input logic area, input logic [4:0] idx,
                                         input ccs_area_t want, input int unsigned n);
        ccs_sel_hit = (area == logic'(want)) && (idx == n[4:0]);
    endfunction : ccs_sel_hit

    // Domain keeps running unless it has a mask and the mask is clear
    function automatic logic ccs_run(input logic stop, input logic has_mask,
                                     input logic mask);
        ccs_run = !(stop && (!has_mask || !mask)) || (has_mask && mask) || !has_mask;
    endfunction : ccs_run

    assign stop_rise = standby_stop_request_i && !s_r.stop_q;
    assign stop_fall = !standby_stop_request_i && s_r.stop_q;

    // Oscillators answer only to power-up reset, the PLL to system and deep-stop wake-up reset
    assign gen_reset[`CCS_GEN_XTAL] = power_up_reset_i;
    assign gen_reset[`CCS_GEN_FAST] = power_up_reset_i;
    assign gen_reset[`CCS_GEN_PLL] = system_reset_i || deep_stop_wakeup_reset_i;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.stop_q = standby_stop_request_i;

        // Generators
        for (int g = 0; g < 3; g++) begin
            if (gen_reset[g]) begin
                s_nxt.gen_run[g] = `CCS_GEN_RUN_RST;
                s_nxt.gen_held[g] = 1'b0;
                s_nxt.gen_mask[g] = `CCS_GEN_MASK_RST;
            end else begin
                if (gen_mask_wr_i) begin
                    s_nxt.gen_mask[g] = gen_stop_mask_i[g];
                end
                if (stop_rise && !s_r.gen_mask[g]) begin
                    s_nxt.gen_held[g] = s_r.gen_run[g];
                    s_nxt.gen_run[g] = 1'b0;
                end else if (standby_stop_request_i && !s_r.gen_mask[g]) begin
                    // Triggers are ignored while halted by stand-by
                    s_nxt.gen_run[g] = 1'b0;
                end else if (stop_fall) begin
                    s_nxt.gen_run[g] = s_r.gen_run[g] || s_r.gen_held[g];
                    s_nxt.gen_held[g] = 1'b0;
                    if (g == `CCS_GEN_XTAL && wakeup_crystal_start_i) begin
                        s_nxt.gen_run[g] = 1'b1;
                    end
                end else if (gen_disable_trg_i[g]) begin
                    s_nxt.gen_run[g] = 1'b0;
                end else if (gen_enable_trg_i[g]) begin
                    s_nxt.gen_run[g] = 1'b1;
                end
            end
        end

        // Selector configuration
        for (int i = 0; i < NI; i++) begin
            if (system_reset_i || deep_stop_wakeup_reset_i) begin
                s_nxt.iso_src[i*SW +: SW] = SW'(`CCS_SEL_SRC_RST);
                s_nxt.iso_mask[i] = `CCS_SEL_MASK_RST;
            end else if (sel_wr_i && ccs_sel_hit(sel_area_i, sel_index_i, CCS_AREA_ISO,
                                                 i)) begin
                s_nxt.iso_src[i*SW +: SW] = sel_source_i;
                s_nxt.iso_mask[i] = sel_stop_mask_i && ISO_HAS_MASK[i];
            end
        end
        for (int a = 0; a < NA; a++) begin
            if (system_reset_i) begin
                s_nxt.awo_src[a*SW +: SW] = SW'(`CCS_SEL_SRC_RST);
                s_nxt.awo_mask[a] = `CCS_SEL_MASK_RST;
            end else if (sel_wr_i && ccs_sel_hit(sel_area_i, sel_index_i, CCS_AREA_AWO,
                                                 a)) begin
                s_nxt.awo_src[a*SW +: SW] = sel_source_i;
                s_nxt.awo_mask[a] = sel_stop_mask_i && AWO_HAS_MASK[a];
            end
        end

        // Domain clock enables, one stop request for a whole area
        for (int i = 0; i < NI; i++) begin
            s_nxt.iso_run[i] = ccs_run(standby_stop_request_i, ISO_HAS_MASK[i],
                                       s_r.iso_mask[i]);
        end
        for (int a = 0; a < NA; a++) begin
            s_nxt.awo_run[a] = ccs_run(standby_stop_request_i, AWO_HAS_MASK[a],
                                       s_r.awo_mask[a]);
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_r.stop_q <= 1'b0;
            s_r.gen_run <= '0;
            s_r.gen_held <= '0;
            s_r.gen_mask <= '0;
            s_r.iso_src <= '0;
            s_r.iso_mask <= '0;
            s_r.iso_run <= '1;
            s_r.awo_src <= '0;
            s_r.awo_mask <= '0;
            s_r.awo_run <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Enables are registered; the downstream latch-based gate takes them
    // while its clock is low, so a stop never clips a pulse
    assign iso_domain_clock_out_o = s_r.iso_run;
    assign awo_domain_clock_out_o = s_r.awo_run;
    assign iso_domain_source_o = s_r.iso_src;
    assign awo_domain_source_o = s_r.awo_src;
    assign gen_running_o = s_r.gen_run;

    // ********************************************************
    // Clock monitors
    // ********************************************************
    // A stopped generator is not measured, else stand-by would look like a fault
    assign mon_active = mon_enable_i & s_r.gen_run;

    for (genvar m = 0; m < 3; m++) begin : g_mon
        ccs_freq_monitor #(
            .WIN_CYC(MON_WIN_CYC),
            .CW(CW)
        ) u_mon (
            .mclk_i(mclk_i),
            .reset_i(reset_i || gen_reset[m]),
            .sup_clk_i(mon_sup_clk_i[m]),
            .enable_i(mon_active[m]),
            .lo_limit_i(mon_lo_limit_i[m*CW +: CW]),
            .hi_limit_i(mon_hi_limit_i[m*CW +: CW]),
            .monitor_reset_out_o(monitor_reset_out_o[m]),
            .monitor_event_out_o(monitor_event_out_o[m])
        );
    end

    // ********************************************************
    // Checks
    // ********************************************************
    a_stop_halts_iso: assert property (@(posedge mclk_i) disable iff (reset_i)
        (standby_stop_request_i && ISO_HAS_MASK[0] && !s_r.iso_mask[0])
        |=> !iso_domain_clock_out_o[0])
        else $error("unmasked iso domain kept running under stop");
    a_mask_keeps_awo: assert property (@(posedge mclk_i) disable iff (reset_i)
        (AWO_HAS_MASK[0] && s_r.awo_mask[0]) |=> awo_domain_clock_out_o[0])
        else $error("masked always-on domain stopped");
    a_no_stop_runs: assert property (@(posedge mclk_i) disable iff (reset_i)
        !standby_stop_request_i |=> (&iso_domain_clock_out_o) && (&awo_domain_clock_out_o))
        else $error("domain clock off without stop request");
    a_gen_halt_stop: assert property (@(posedge mclk_i) disable iff (reset_i)
        (stop_rise && !s_r.gen_mask[`CCS_GEN_PLL] && !gen_reset[`CCS_GEN_PLL])
        |=> !gen_running_o[`CCS_GEN_PLL]
        ##1 (!gen_running_o[`CCS_GEN_PLL] || !$past(standby_stop_request_i)))
        else $error("pll kept running after unmasked stop");
    a_gen_restart: assert property (@(posedge mclk_i) disable iff (reset_i)
        (stop_fall && s_r.gen_held[`CCS_GEN_FAST] && !power_up_reset_i)
        |=> gen_running_o[`CCS_GEN_FAST])
        else $error("fast oscillator did not restart at wake-up");
    a_xtal_wakeup: assert property (@(posedge mclk_i) disable iff (reset_i)
        (stop_fall && wakeup_crystal_start_i && !power_up_reset_i
         && !(standby_stop_request_i && !s_r.gen_mask[`CCS_GEN_XTAL]))
        |=> gen_running_o[`CCS_GEN_XTAL])
        else $error("crystal not started by wake-up start");
    a_deep_wake_sel: assert property (@(posedge mclk_i) disable iff (reset_i)
        deep_stop_wakeup_reset_i |=> iso_domain_source_o == '0 && s_r.iso_mask == '0)
        else $error("iso selectors not reset by deep-stop wake-up");
    a_osc_keep_sys: assert property (@(posedge mclk_i) disable iff (reset_i)
        (system_reset_i && !power_up_reset_i && !standby_stop_request_i && !stop_fall
         && gen_disable_trg_i == '0 && gen_running_o[`CCS_GEN_XTAL])
        |=> gen_running_o[`CCS_GEN_XTAL] && !gen_running_o[`CCS_GEN_PLL])
        else $error("system reset hit the crystal or missed the pll");
    a_sys_sel_default: assert property (@(posedge mclk_i) disable iff (reset_i)
        system_reset_i |=> awo_domain_source_o == '0 && iso_domain_source_o == '0)
        else $error("selectors not defaulted by system reset");

    // ********************************************************
    // Further checks
    // ********************************************************
    // Generators
    a_trg_held_stop: assert property (@(posedge mclk_i) disable iff (reset_i)
        (standby_stop_request_i && !stop_rise && !s_r.gen_mask[`CCS_GEN_PLL])
        |=> !gen_running_o[`CCS_GEN_PLL])
        else $error("pll trigger taken under stop");
    a_mask_keeps_gen: assert property (@(posedge mclk_i) disable iff (reset_i)
        (standby_stop_request_i && s_r.gen_mask[`CCS_GEN_FAST] && !power_up_reset_i
         && !gen_enable_trg_i[`CCS_GEN_FAST] && !gen_disable_trg_i[`CCS_GEN_FAST])
        |=> $stable(gen_running_o[`CCS_GEN_FAST]))
        else $error("masked fast oscillator changed under stop");
    a_gen_stay_off: assert property (@(posedge mclk_i) disable iff (reset_i)
        (stop_fall && !s_r.gen_run[`CCS_GEN_PLL] && !s_r.gen_held[`CCS_GEN_PLL])
        |=> !gen_running_o[`CCS_GEN_PLL])
        else $error("stopped pll woke up");
    a_pll_sys_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
        system_reset_i |=> !gen_running_o[`CCS_GEN_PLL])
        else $error("pll survived system reset");
    a_osc_pur_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
        power_up_reset_i |=> gen_running_o[1:0] == 2'h0)
        else $error("oscillator survived power-up reset");

    // Monitors
    a_event_has_rst: assert property (@(posedge mclk_i) disable iff (reset_i)
        (monitor_event_out_o & ~monitor_reset_out_o) == 3'h0)
        else $error("monitor event without reset output");

    // Selectors
    // Writes to iso selector 0 must land; deep-stop wake-up and out-of-range writes leave always-on selectors as they were
    a_sel_write_iso: assert property (@(posedge mclk_i) disable iff (reset_i)
        (sel_wr_i && !sel_area_i && sel_index_i == 5'h00 && !system_reset_i
         && !deep_stop_wakeup_reset_i)
        |=> iso_domain_source_o[SW-1:0] == $past(sel_source_i))
        else $error("iso selector write lost");
    a_awo_keep_deep: assert property (@(posedge mclk_i) disable iff (reset_i)
        (deep_stop_wakeup_reset_i && !system_reset_i && !sel_wr_i)
        |=> $stable(awo_domain_source_o))
        else $error("deep-stop wake-up hit always-on selectors");
    a_sel_range: assert property (@(posedge mclk_i) disable iff (reset_i)
        (sel_wr_i && sel_area_i && sel_index_i >= NA && !system_reset_i)
        |=> $stable(awo_domain_source_o))
        else $error("out-of-range write changed a selector");
endmodule : ccs_clock_ctrl
`default_nettype wire

// *** core/ccs_freq_monitor.sv ***
// Frequency monitor of one supervised clock
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_freq_monitor
    import ccs_pkg::*;
#(
    parameter int WIN_CYC = `CCS_MON_WIN_CYC,
    parameter int CW = 16
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic sup_clk_i,
    input wire logic enable_i,
    input wire logic [CW-1:0] lo_limit_i,
    input wire logic [CW-1:0] hi_limit_i,
    output logic monitor_reset_out_o,
    output logic monitor_event_out_o
);
    if (WIN_CYC < 2 || WIN_CYC >= (1 << CW)) begin : g_chk
        $error("ccs_freq_monitor: window does not fit the counter");
    end

    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic [CW-1:0] win_cnt;
        logic [CW-1:0] edge_cnt;
        ccs_mon_state_t st;
        logic event_p;
    } ccs_mon_t;

    ccs_mon_t s_r;
    ccs_mon_t s_nxt;
    logic rise;
    logic win_end;

    function automatic logic ccs_out_of_window(input logic [CW-1:0] n,
                                               input logic [CW-1:0] lo,
                                               input logic [CW-1:0] hi);
        ccs_out_of_window = (n < lo) || (n > hi);
    endfunction : ccs_out_of_window

    // Edge counts only once second and third stages agree
    assign rise = (s_r.sync[1] == s_r.sync[2]) && s_r.sync[2] && !s_r.level;
    assign win_end = (s_r.win_cnt == CW'(WIN_CYC - 1));

    always_comb begin
        s_nxt = s_r;
        s_nxt.event_p = 1'b0;
        s_nxt.sync = {s_r.sync[1:0], sup_clk_i};
        if (s_r.sync[1] == s_r.sync[2]) begin
            s_nxt.level = s_r.sync[2];
        end
        case (s_r.st)
            CCS_MON_IDLE: begin
                s_nxt.win_cnt = '0;
                s_nxt.edge_cnt = '0;
                if (enable_i) begin
                    s_nxt.st = CCS_MON_MEASURE;
                end
            end
            CCS_MON_MEASURE: begin
                if (!enable_i) begin
                    s_nxt.st = CCS_MON_IDLE;
                end else if (win_end) begin
                    s_nxt.win_cnt = '0;
                    s_nxt.edge_cnt = '0;
                    if (ccs_out_of_window(s_r.edge_cnt, lo_limit_i, hi_limit_i)) begin
                        s_nxt.st = CCS_MON_FAULT;
                        s_nxt.event_p = 1'b1;
                    end
                end else begin
                    s_nxt.win_cnt = s_r.win_cnt + CW'(1);
                    if (rise && s_r.edge_cnt != '1) begin
                        s_nxt.edge_cnt = s_r.edge_cnt + CW'(1);
                    end
                end
            end
            CCS_MON_FAULT: begin
                // Fault holds until enable_i drops or reset_i is raised
                if (!enable_i) begin
                    s_nxt.st = CCS_MON_IDLE;
                end
            end
            default: begin
                s_nxt.st = CCS_MON_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign monitor_reset_out_o = (s_r.st == CCS_MON_FAULT);
    assign monitor_event_out_o = s_r.event_p;

    a_fault_sets_reset: assert property (@(posedge mclk_i) disable iff (reset_i)
        (s_r.st == CCS_MON_MEASURE && enable_i && win_end
         && ((s_r.edge_cnt < lo_limit_i) || (s_r.edge_cnt > hi_limit_i)))
        |=> monitor_reset_out_o && monitor_event_out_o)
        else $error("monitor missed an out-of-window count");
    a_event_single_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(monitor_event_out_o) |=> !monitor_event_out_o && monitor_reset_out_o)
        else $error("monitor event longer than one cycle");
endmodule : ccs_freq_monitor
`default_nettype wire

// *** core/ccs_pkg.sv ***
// Types shared by the clock control and stand-by block
package ccs_pkg;
    typedef enum logic {
        CCS_AREA_ISO,
        CCS_AREA_AWO
    } ccs_area_t;

    typedef enum logic [1:0] {
        CCS_MON_IDLE,
        CCS_MON_MEASURE,
        CCS_MON_FAULT
    } ccs_mon_state_t;
endpackage : ccs_pkg

// *** core/ccs_regs.svh ***
// Constants of the clock control and stand-by block
//
// Summary of operation
// - Three monitors watch the crystal, fast internal oscillator and PLL output.
// - Each monitor flags its supervised clock running at abnormal frequency.
// - Each monitor has a reset output usable by the reset controller.
// - Monitor event output serves as interrupt request where wired.
// - Stop request halts generators and both areas' domain clocks.
// - One stop request stops together all domain clocks of its power domain whose stop mask is clear; domains without a mask keep running.
// - Generators and most selectors have a stop mask keeping clock running.
// - Every clock domain has its own selector; those with a stop mask have own stop control.
// - Each selector output feeds exactly one domain, by area and index.
// - Deep-stop wake-up resets all isolated-area selectors.
// - Wake-up crystal start turns the crystal oscillator on at wake-up.
// - Mask clear lets stop halt the domain clock; mask set keeps it.
// - PLL reset by system reset; oscillators only by power-up reset.
// - All selectors return to default source on system reset.
// - Stopped PLL and fast oscillator restart at wake-up only if running before entry.
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

`define CCS_CLK_PERIOD_NS 40
`define CCS_MON_WIN_NS 10000
`define CCS_MON_WIN_CYC (`CCS_MON_WIN_NS / `CCS_CLK_PERIOD_NS)
`define CCS_SEL_SRC_RST 3'h0
`define CCS_SEL_MASK_RST 1'b0
`define CCS_GEN_RUN_RST 1'b0
`define CCS_GEN_MASK_RST 1'b0
`define CCS_GEN_XTAL 0
`define CCS_GEN_FAST 1
`define CCS_GEN_PLL 2
`define CCS_NUM_ISO 12
`define CCS_NUM_AWO 4
`define CCS_SRC_W 3

`endif

// *** tb/ccs_stby_model.sv ***
// Behavioural reset and stand-by controller facing the clock block
`timescale 1ns/1ps
`default_nettype none
module ccs_stby_model (
    input wire logic mclk_i,
    input wire logic por_cmd_i,
    input wire logic dbg_cmd_i,
    input wire logic int_rst_cmd_i,
    input wire logic stop_cmd_i,
    input wire logic deep_cmd_i,
    input wire logic wake_cmd_i,
    input wire logic wuosc_en_i,
    input wire logic [2:0] wake_en_i,
    input wire logic [2:0] mon_event_i,
    output logic power_up_reset_o,
    output logic system_reset_o,
    output logic standby_stop_request_o,
    output logic deep_stop_wakeup_reset_o,
    output logic wakeup_crystal_start_o
);
    typedef struct packed {
        logic stop;
        logic deep;
        logic dpwu;
    } ccs_stby_st_t;
    ccs_stby_st_t st_r;
    ccs_stby_st_t st_nxt;
    logic wake;

    assign power_up_reset_o = por_cmd_i | dbg_cmd_i;
    assign system_reset_o = power_up_reset_o | int_rst_cmd_i;
    assign standby_stop_request_o = st_r.stop;
    assign deep_stop_wakeup_reset_o = st_r.dpwu;
    // Crystal start only as far as the model's own enable allows
    assign wakeup_crystal_start_o = wuosc_en_i;

    always_comb begin
        wake = wake_cmd_i | (|(mon_event_i & wake_en_i));
        st_nxt = st_r;
        st_nxt.dpwu = 1'b0;
        if (stop_cmd_i && !st_r.stop) begin
            st_nxt.stop = 1'b1;
            st_nxt.deep = deep_cmd_i;
        end else if (st_r.stop && wake) begin
            st_nxt.stop = 1'b0;
            st_nxt.deep = 1'b0;
            st_nxt.dpwu = st_r.deep;
        end
        if (system_reset_o) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end
endmodule : ccs_stby_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench of the clock control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SW = 3;
    localparam int CW = 16;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic por = 1'b1, dbg = 1'b0, irst = 1'b0, stp = 1'b0, deep = 1'b0, wake = 1'b0;
    logic wuen = 1'b0, gmask_wr = 1'b0, sel_wr = 1'b0, sel_area = 1'b0, sel_mask = 1'b0;
    logic [2:0] wken = 3'h0, en_trg = 3'h0, dis_trg = 3'h0, gmask = 3'h0, mon_en = 3'h0;
    logic [4:0] sel_idx = 5'h00;
    logic [SW-1:0] sel_src = 3'h0;
    logic [3*CW-1:0] lo_lim = '0, hi_lim = '1;
    logic [3:0] sup_cnt = 4'h0;
    logic pur, sys, stop, dpwu, wuosc;
    logic [2:0] running, mrst, mevt;
    logic [12*SW-1:0] isrc;
    logic [11:0] ien;
    logic [4*SW-1:0] asrc;
    logic [3:0] aen;
    int error_cnt = 0;
    int n_compared = 0;

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    // Supervised clock at a quarter of the system clock
    always @(posedge mclk_i) begin
        #1 sup_cnt <= sup_cnt + 4'h1;
    end

    ccs_stby_model partner (.mclk_i(mclk_i), .por_cmd_i(por), .dbg_cmd_i(dbg),
        .int_rst_cmd_i(irst), .stop_cmd_i(stp), .deep_cmd_i(deep), .wake_cmd_i(wake),
        .wuosc_en_i(wuen), .wake_en_i(wken), .mon_event_i(mevt), .power_up_reset_o(pur),
        .system_reset_o(sys), .standby_stop_request_o(stop),
        .deep_stop_wakeup_reset_o(dpwu), .wakeup_crystal_start_o(wuosc));

    ccs_clock_ctrl #(.MON_WIN_CYC(16)) dut (.mclk_i(mclk_i), .reset_i(reset_i),
        .power_up_reset_i(pur), .system_reset_i(sys), .standby_stop_request_i(stop),
        .deep_stop_wakeup_reset_i(dpwu), .wakeup_crystal_start_i(wuosc),
        .gen_enable_trg_i(en_trg), .gen_disable_trg_i(dis_trg), .gen_mask_wr_i(gmask_wr),
        .gen_stop_mask_i(gmask), .sel_wr_i(sel_wr), .sel_area_i(sel_area),
        .sel_index_i(sel_idx), .sel_source_i(sel_src), .sel_stop_mask_i(sel_mask),
        .mon_enable_i(mon_en), .mon_sup_clk_i({3{sup_cnt[1]}}), .mon_lo_limit_i(lo_lim),
        .mon_hi_limit_i(hi_lim), .gen_running_o(running), .iso_domain_source_o(isrc),
        .iso_domain_clock_out_o(ien), .awo_domain_source_o(asrc),
        .awo_domain_clock_out_o(aen), .monitor_reset_out_o(mrst),
        .monitor_event_out_o(mevt));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    task automatic gen(input logic [2:0] en, input logic [2:0] dis);
        en_trg = en;
        dis_trg = dis;
        tick(1);
        en_trg = 3'h0;
        dis_trg = 3'h0;
        tick(1);
    endtask : gen

    task automatic set_gmask(input logic [2:0] m);
        gmask = m;
        gmask_wr = 1'b1;
        tick(1);
        gmask_wr = 1'b0;
    endtask : set_gmask

    task automatic sel(input logic a, input logic [4:0] i, input logic [2:0] s, input logic m);
        sel_area = a;
        sel_idx = i;
        sel_src = s;
        sel_mask = m;
        sel_wr = 1'b1;
        tick(1);
        sel_wr = 1'b0;
        tick(1);
    endtask : sel

    // Stop and wake are commands to the partner, which answers a cycle later
    task automatic standby(input logic d);
        deep = d;
        stp = 1'b1;
        tick(1);
        stp = 1'b0;
        tick(4);
    endtask : standby

    task automatic wakeup;
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(4);
    endtask : wakeup

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_reset;
        chk("gen_running", 64'h0, running);
        chk("iso_src", 64'h0, isrc);
        chk("iso_en", 64'hFFF, ien);
        chk("awo_en", 64'hF, aen);
        chk("mon_rst", 64'h0, mrst);
    endtask : s_reset

    task automatic s_sel;
        sel(1'b0, 5'h05, 3'h3, 1'b1);
        sel(1'b1, 5'h02, 3'h5, 1'b0);
        sel(1'b0, 5'h0C, 3'h7, 1'b1);
        sel(1'b1, 5'h04, 3'h7, 1'b1);
        tick(1);
        chk("iso_src", 64'h3 << 15, isrc);
        chk("awo_src", 64'h5 << 6, asrc);
    endtask : s_sel

    task automatic s_stop;
        gen(3'h7, 3'h4);
        chk("gen_running", 64'h3, running);
        standby(1'b0);
        chk("gen_running", 64'h0, running);
        chk("iso_en", 64'h020, ien);
        chk("awo_en", 64'h0, aen);
        gen(3'h1, 3'h0);
        chk("gen_running", 64'h0, running);
        wakeup;
        chk("gen_running", 64'h3, running);
        chk("iso_en", 64'hFFF, ien);
        chk("awo_en", 64'hF, aen);
        set_gmask(3'h2);
        standby(1'b0);
        chk("gen_running", 64'h2, running);
        wakeup;
    endtask : s_stop

    task automatic s_wuosc;
        gen(3'h0, 3'h1);
        chk("gen_running", 64'h2, running);
        wuen = 1'b1;
        standby(1'b0);
        wakeup;
        wuen = 1'b0;
        chk("gen_running", 64'h3, running);
    endtask : s_wuosc

    task automatic s_deep;
        gen(3'h4, 3'h0);
        standby(1'b1);
        chk("gen_running", 64'h2, running);
        wakeup;
        chk("iso_src", 64'h0, isrc);
        chk("awo_src", 64'h5 << 6, asrc);
        sel(1'b0, 5'h00, 3'h3, 1'b1);
        chk("iso_src", 64'h3, isrc);
    endtask : s_deep

    task automatic s_mon;
        int nev;
        nev = 0;
        set_gmask(3'h1);
        lo_lim[CW-1:0] = 16'h0002;
        hi_lim[CW-1:0] = 16'h0006;
        mon_en = 3'h1;
        tick(60);
        chk("mon_rst", 64'h0, mrst);
        wken = 3'h1;
        standby(1'b0);
        chk("stop_req", 64'h1, stop);
        lo_lim[CW-1:0] = 16'h0008;
        // Fixed span: a fault needs at most two windows plus sync delay
        repeat (100) begin
            tick(1);
            nev = nev + int'(mevt[0] === 1'b1);
        end
        chk("mon_rst", 64'h1, mrst);
        chk("mon_evt_count", 64'h1, nev);
        chk("stop_req", 64'h0, stop);
        mon_en = 3'h0;
        wken = 3'h0;
        tick(4);
        chk("mon_rst", 64'h0, mrst);
    endtask : s_mon

    task automatic s_rst;
        gen(3'h7, 3'h0);
        sel(1'b1, 5'h03, 3'h6, 1'b1);
        irst = 1'b1;
        tick(1);
        irst = 1'b0;
        tick(3);
        chk("gen_running", 64'h3, running);
        chk("awo_src", 64'h0, asrc);
        dbg = 1'b1;
        tick(1);
        dbg = 1'b0;
        tick(3);
        chk("gen_running", 64'h0, running);
    endtask : s_rst

    task automatic complete_run;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        tick(10);
        reset_i = 1'b0;
        por = 1'b0;
        tick(1);
        s_reset;
        s_sel;
        s_stop;
        s_wuosc;
        s_deep;
        s_mon;
        s_rst;
        complete_run;
    end
endmodule : tb
`default_nettype wire
